// *** common/wdt_pkg.sv ***
// Purpose: Shared constants and types for the watchdog and reset-cause block.
// Assumes: An 8-bit I/O register port driven by the processor core.
// Notes:   Field positions below are bit indices inside each 8-bit register.
package wdt_pkg;

  // Reset-cause register fields.
  localparam int unsigned RC_DEBUG = 4;
  localparam int unsigned RC_WD    = 3;
  localparam int unsigned RC_BROWN = 2;
  localparam int unsigned RC_PIN   = 1;
  localparam int unsigned RC_POR   = 0;
  localparam int unsigned RC_W     = 5;
  localparam logic [RC_W-1:0] RC_RST_VAL = 5'h01;

  // Watchdog control and status register fields.
  localparam int unsigned WC_IRQ_FLAG = 7;
  localparam int unsigned WC_IRQ_EN   = 6;
  localparam int unsigned WC_PS_MSB   = 5;
  localparam int unsigned WC_CHG_EN   = 4;
  localparam int unsigned WC_SYS_EN   = 3;
  localparam int unsigned WC_PS_LO    = 2;
  localparam logic [3:0]  WC_PS_RST   = 4'h0;

  // Change window length in system clock cycles.
  localparam int unsigned CE_HOLD_CYC = 4;
  localparam logic [1:0]  CE_LAST     = 2'(CE_HOLD_CYC - 1);

  // Time-out in watchdog oscillator cycles for select code zero.
  localparam int unsigned WD_BASE_CYC = 2048;
  localparam int unsigned WD_OSC_HZ   = 128000;
  localparam logic [3:0]  WD_SEL_MAX  = 4'h9;
  localparam int unsigned WD_CNT_W    = 20;

  // Synchroniser lanes for the asynchronous inputs.
  localparam int unsigned SY_OSC   = 0;
  localparam int unsigned SY_FUSE  = 1;
  localparam int unsigned SY_PIN   = 2;
  localparam int unsigned SY_BROWN = 3;
  localparam int unsigned SY_DEBUG = 4;
  localparam int unsigned SY_W     = 5;

  typedef enum logic {
    REG_CAUSE = 1'h0,
    REG_WDCTL = 1'h1
  } reg_sel_e;

  typedef struct packed {
    logic [RC_W-1:0] cause;
    logic            irq_flag;
    logic            irq_en;
    logic            sys_en;
    logic            chg_en;
    logic [1:0]      chg_cnt;
    logic [3:0]      ps_sel;
    logic            rst_pulse;
    logic [7:0]      rdata;
  } wdt_s;

  typedef struct packed {
    logic                osc_prev;
    logic [WD_CNT_W-1:0] count;
    logic                timeout;
  } cnt_s;

endpackage

// *** common/wd_cnt_if.sv ***
// Purpose: Carries control and time-out between the register logic and counter.
// Assumes: Both ends run on the system clock.
// Notes:   osc_lvl is the already synchronised oscillator level.
`timescale 1ns/10ps
interface wd_cnt_if;
  logic       osc_lvl;
  logic       run;
  logic       restart;
  logic [3:0] sel;
  logic       timeout;

  modport ctrl (output osc_lvl, output run, output restart, output sel, input timeout);
  modport cnt  (input osc_lvl, input run, input restart, input sel, output timeout);
endinterface

// *** hw/sync3.sv ***
// Purpose: Three-stage synchroniser with an agreement filter, W lanes wide.
// Assumes: Inputs are slow compared with the system clock.
// Notes:   The output only moves when stages two and three agree.
`timescale 1ns/10ps
module sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.s1  = d_i;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    st_nxt.lvl = (st_r.s2 & st_r.s3) | (st_r.lvl & (st_r.s2 | st_r.s3));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.lvl;

endmodule

// *** hw/wd_timeout_counter.sv ***
// Purpose: Counts watchdog oscillator edges and flags the selected time-out.
// Assumes: The oscillator level arrives already synchronised.
// Notes:   Reserved select codes behave as the longest time-out.
`timescale 1ns/10ps
module wd_timeout_counter
  import wdt_pkg::*;
#(
  parameter int unsigned BASE_CYC = WD_BASE_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  wd_cnt_if.cnt     port_if
);

  cnt_s st_r;
  cnt_s st_nxt;
  logic tick;
  logic at_last;

  function automatic logic [WD_CNT_W-1:0] last_count(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > WD_SEL_MAX) ? WD_SEL_MAX : sel;
    return WD_CNT_W'((BASE_CYC << s) - 1);
  endfunction

  assign tick    = port_if.osc_lvl && !st_r.osc_prev;
  // Compare with >= so a switch to a shorter period cannot skip the end.
  assign at_last = st_r.count >= last_count(port_if.sel);

  always_comb begin
    st_nxt          = st_r;
    st_nxt.osc_prev = port_if.osc_lvl;
    st_nxt.timeout  = 1'h0;
    if (!port_if.run || port_if.restart) begin
      st_nxt.count = '0;
    end else if (tick) begin
      if (at_last) begin
        st_nxt.count   = '0;
        st_nxt.timeout = 1'h1;
      end else begin
        st_nxt.count = st_r.count + WD_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_if.timeout = st_r.timeout;

  a_tmo_on_last: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    port_if.run && !port_if.restart && tick && at_last |=> port_if.timeout)
    else $error("Time-out missing at end of period.");

  a_tmo_single: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    port_if.timeout |=> !port_if.timeout)
    else $error("Time-out lasted more than one cycle.");

endmodule

// *** hw/wdt_reset_cause.sv ***
// Purpose: Watchdog control/status and reset-cause registers with the watchdog.
// Assumes: Core I/O writes are one-cycle strobes; resets are external levels.
// Notes:   arst_n_i is the power-on reset; other resets do not clear this block.
`timescale 1ns/10ps

module wdt_reset_cause
  import wdt_pkg::*;
#(
  parameter int unsigned BASE_CYC = WD_BASE_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_sel_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  input  wire logic       wdr_i,
  input  wire logic       irq_ack_i,
  input  wire logic       global_irq_en_i,
  input  wire logic       wd_osc_i,
  input  wire logic       wd_always_on_fuse_i,
  input  wire logic       pin_reset_i,
  input  wire logic       brownout_reset_i,
  input  wire logic       scan_reset_i,
  output logic            wd_sysreset_o,
  output logic            wd_irq_o
);

  logic [1:0]      rst_sync_r;
  logic            rst_n;
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy_lvl;
  wdt_s            st_r;
  wdt_s            st_nxt;
  logic            fuse_prog;
  logic            eff_sys_en;
  logic            eff_irq_en;
  logic            wr_cause;
  logic            wr_ctl;
  logic            open_wr;
  logic            tmo;
  logic            fire_reset;
  logic            set_irq;
  logic [7:0]      ctl_view;
  logic [7:0]      cause_view;

  wd_cnt_if cnt_if ();

  // The reset is released synchronously so no flop sees a partial release.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_r[1];

  assign sy_in[SY_OSC]   = wd_osc_i;
  assign sy_in[SY_FUSE]  = wd_always_on_fuse_i;
  assign sy_in[SY_PIN]   = pin_reset_i;
  assign sy_in[SY_BROWN] = brownout_reset_i;
  assign sy_in[SY_DEBUG] = scan_reset_i;

  sync3 #(
    .W (SY_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .d_i        (sy_in),
    .q_o        (sy_lvl)
  );

  wd_timeout_counter #(
    .BASE_CYC (BASE_CYC)
  ) u_counter (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .port_if    (cnt_if.cnt)
  );

  assign fuse_prog = !sy_lvl[SY_FUSE];

  assign eff_sys_en = st_r.sys_en || st_r.cause[RC_WD] || fuse_prog;

  assign eff_irq_en = st_r.irq_en && !fuse_prog;

  assign wr_cause = io_wr_i && (io_sel_i == REG_CAUSE);
  assign wr_ctl   = io_wr_i && (io_sel_i == REG_WDCTL);

  // Window opens only on both ones.
  assign open_wr = wr_ctl && io_wdata_i[WC_CHG_EN] && io_wdata_i[WC_SYS_EN];

  assign cnt_if.osc_lvl = sy_lvl[SY_OSC];
  assign cnt_if.run     = eff_sys_en || eff_irq_en;
  assign cnt_if.restart = wdr_i;
  assign cnt_if.sel     = st_r.ps_sel;
  assign tmo            = cnt_if.timeout;

  assign fire_reset = tmo && eff_sys_en && (!eff_irq_en || st_r.irq_flag);

  assign set_irq = tmo && eff_irq_en;

  assign ctl_view = {st_r.irq_flag, eff_irq_en, st_r.ps_sel[3], st_r.chg_en,
                     eff_sys_en, st_r.ps_sel[2:0]};
  assign cause_view = {3'h0, st_r.cause};

  always_comb begin
    st_nxt           = st_r;
    st_nxt.rst_pulse = fire_reset;
    st_nxt.rdata     = (io_sel_i == REG_WDCTL) ? ctl_view : cause_view;

    // Software clears cause flags by writing zeros; ones are ignored.
    if (wr_cause) begin
      st_nxt.cause = st_r.cause & io_wdata_i[RC_W-1:0];
    end

    // Hardware sets come after the clear so a same-cycle event survives.
    // Debug reset cause.
    if (sy_lvl[SY_DEBUG]) begin
      st_nxt.cause[RC_DEBUG] = 1'h1;
    end
    if (sy_lvl[SY_BROWN]) begin
      st_nxt.cause[RC_BROWN] = 1'h1;
    end
    if (sy_lvl[SY_PIN]) begin
      st_nxt.cause[RC_PIN] = 1'h1;
    end
    if (fire_reset) begin
      st_nxt.cause[RC_WD] = 1'h1;
    end

    if (wr_ctl) begin
      if (io_wdata_i[WC_SYS_EN]) begin
        st_nxt.sys_en = 1'h1;
      end else if (st_r.chg_en) begin
        st_nxt.sys_en = 1'h0;
      end
      if (st_r.chg_en) begin
        st_nxt.ps_sel = {io_wdata_i[WC_PS_MSB], io_wdata_i[WC_PS_LO:0]};
      end
      st_nxt.irq_en = io_wdata_i[WC_IRQ_EN];
      if (io_wdata_i[WC_IRQ_FLAG]) begin
        st_nxt.irq_flag = 1'h0;
      end
      // Any other write consumes or refuses the window.
      st_nxt.chg_en  = open_wr;
      st_nxt.chg_cnt = CE_LAST;
    end else if (st_r.chg_en) begin
      if (st_r.chg_cnt == 2'h0) begin
        st_nxt.chg_en = 1'h0;
      end else begin
        st_nxt.chg_cnt = st_r.chg_cnt - 2'h1;
      end
    end

    if (irq_ack_i) begin
      st_nxt.irq_flag = 1'h0;
      if (eff_sys_en) begin
        st_nxt.irq_en = 1'h0;
      end
    end

    if (set_irq) begin
      st_nxt.irq_flag = 1'h1;
    end

    if (st_nxt.cause[RC_WD]) begin
      st_nxt.sys_en = 1'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.cause     <= RC_RST_VAL;
      st_r.ps_sel    <= WC_PS_RST;
      st_r.rst_pulse <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata_o    = st_r.rdata;
  assign wd_sysreset_o = st_r.rst_pulse;
  assign wd_irq_o      = global_irq_en_i && eff_irq_en && st_r.irq_flag;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_open;
    open_wr;
  endsequence

  sequence s_quiet4;
    !io_wr_i [*4];
  endsequence

  a_ce_opens: assert property (s_open |=> st_r.chg_en)
    else $error("Change enable did not open.");

  a_ce_closes: assert property (s_open ##1 s_quiet4 |=> !st_r.chg_en)
    else $error("Change enable not cleared after four cycles.");

  a_ce_holds: assert property (s_open ##1 !io_wr_i [*3] |-> st_r.chg_en)
    else $error("Change enable closed early.");

  a_sel_locked: assert property (wr_ctl && !st_r.chg_en |=> $stable(st_r.ps_sel))
    else $error("Select changed with window closed.");

  a_sysen_locked: assert property (wr_ctl && !st_r.chg_en && eff_sys_en |=> eff_sys_en)
    else $error("Reset enable cleared with window closed.");

  a_cause_forces: assert property (st_r.cause[RC_WD] |-> st_r.sys_en && ctl_view[WC_SYS_EN])
    else $error("Reset enable not forced by cause flag.");

  a_pulse_width: assert property (wd_sysreset_o |=> !wd_sysreset_o)
    else $error("Reset pulse longer than one cycle.");

  a_pulse_flag: assert property (wd_sysreset_o |-> st_r.cause[RC_WD])
    else $error("Reset pulse without cause flag.");

  a_second_tmo: assert property (tmo && st_r.irq_flag && eff_irq_en && eff_sys_en
    |=> wd_sysreset_o)
    else $error("Unserviced time-out gave no reset.");

  a_vector_drop: assert property (irq_ack_i && eff_sys_en && !set_irq
    |=> !st_r.irq_en && !st_r.irq_flag)
    else $error("Vector did not drop to reset-only mode.");

  a_irq_gate: assert property (!global_irq_en_i || !st_r.irq_flag |-> !wd_irq_o)
    else $error("Interrupt requested while gated.");

  a_fuse_lock: assert property (fuse_prog |-> eff_sys_en && !ctl_view[WC_IRQ_EN])
    else $error("Fuse did not lock the enables.");

  a_pin_flag: assert property (sy_lvl[SY_PIN] |=> st_r.cause[RC_PIN])
    else $error("Pin reset flag not set.");

  a_tmo_irq: assert property (set_irq |=> st_r.irq_flag)
    else $error("Time-out did not set interrupt flag.");

  a_ce_refused: assert property (wr_ctl && !open_wr |=> !st_r.chg_en)
    else $error("Change window opened without both bits.");

  a_debug_flag: assert property (sy_lvl[SY_DEBUG] |=> st_r.cause[RC_DEBUG])
    else $error("Debug reset flag not set.");

  a_brown_flag: assert property (sy_lvl[SY_BROWN] |=> st_r.cause[RC_BROWN])
    else $error("Brown-out reset flag not set.");

  a_por_kept: assert property (st_r.cause[RC_POR] && !wr_cause |=> st_r.cause[RC_POR])
    else $error("Power-on flag lost without a write.");

  a_flag_clear: assert property (wr_ctl && io_wdata_i[WC_IRQ_FLAG] && !set_irq
    |=> !st_r.irq_flag)
    else $error("Written one did not clear interrupt flag.");

  a_stop_quiet: assert property (!cnt_if.run |=> !tmo)
    else $error("Time-out while watchdog stopped.");

endmodule

// *** verification/wdt_reset_cause_test.sv ***
// Purpose: Self-checking bench for the watchdog and reset-cause block.
// Assumes: BASE_CYC shortened to 4; oscillator sped up to a 160 ns period.
// Notes:   Reserved select codes are not timed, as they would run too long.
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module wdt_reset_cause_test;
  import wdt_pkg::*;
  localparam int unsigned BASE = 4;
  localparam int unsigned OSC_P = 160;
  logic       core_clk_i = 0, arst_n_i = 0, io_wr_i = 0, io_sel_i = 0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic       wdr_i = 0, irq_ack_i = 0, global_irq_en_i = 0, wd_osc_i = 0;
  logic       fuse = 1, pin_rst = 0, brown_rst = 0, scan_rst = 0;
  logic       wd_sysreset_o, wd_irq_o;
  int         err_count = 0;
  int         samples_checked = 0;
  logic [7:0] d;
  time        t0, t1;

  wdt_reset_cause #(.BASE_CYC(BASE)) i_dut (
    .core_clk_i         (core_clk_i),
    .arst_n_i           (arst_n_i),
    .io_wr_i            (io_wr_i),
    .io_sel_i           (io_sel_i),
    .io_wdata_i         (io_wdata_i),
    .io_rdata_o         (io_rdata_o),
    .wdr_i              (wdr_i),
    .irq_ack_i          (irq_ack_i),
    .global_irq_en_i    (global_irq_en_i),
    .wd_osc_i           (wd_osc_i),
    .wd_always_on_fuse_i(fuse),
    .pin_reset_i        (pin_rst),
    .brownout_reset_i   (brown_rst),
    .scan_reset_i       (scan_rst),
    .wd_sysreset_o      (wd_sysreset_o),
    .wd_irq_o           (wd_irq_o)
  );

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // The oscillator toggles on falling clock edges, clear of the sampling edge.
  initial begin
    forever #(OSC_P / 2) wd_osc_i = ~wd_osc_i;
  end

  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic s, input logic [7:0] v);
    @(negedge core_clk_i);
    io_sel_i = s;
    io_wdata_i = v;
    io_wr_i = 1;
    @(negedge core_clk_i);
    io_wr_i = 0;
  endtask

  task automatic rd(input logic s, output logic [7:0] v);
    @(negedge core_clk_i);
    io_sel_i = s;
    repeat (2) @(negedge core_clk_i);
    v = io_rdata_o;
  endtask

  task automatic kick;
    @(negedge core_clk_i);
    wdr_i = 1;
    @(negedge core_clk_i);
    wdr_i = 0;
  endtask

  task automatic ack;
    @(negedge core_clk_i);
    irq_ack_i = 1;
    @(negedge core_clk_i);
    irq_ack_i = 0;
  endtask

  // Waits, bounded, for a reset pulse and checks that it lasts one cycle.
  task automatic wait_rst(output time t);
    int n;
    n = 0;
    while (wd_sysreset_o !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    t = $time;
    `CHK(wd_sysreset_o, 1'b1)
    @(negedge core_clk_i);
    `CHK(wd_sysreset_o, 1'b0)
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (wd_irq_o !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    `CHK(wd_irq_o, 1'b1)
  endtask

  task automatic meas(input int unsigned sel);
    int unsigned n;
    n = BASE << sel;
    kick;
    t0 = $time;
    wait_rst(t1);
    `CHK((t1 - t0) >= (n - 1) * OSC_P && (t1 - t0) <= n * OSC_P + 100, 1'b1)
  endtask

  // Closes the watchdog fully: interrupt bits first, then the cause flag, then the timed sequence.
  task automatic stop_all;
    kick;
    wr(1'b1, 8'h80);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h18);
    wr(1'b1, 8'h00);
    rd(1'b1, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_reset_values;
    rd(1'b0, d);
    `CHK(d, 8'h01)
    rd(1'b1, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_causes;
    @(negedge core_clk_i);
    {pin_rst, brown_rst, scan_rst} = 3'h7;
    repeat (5) @(negedge core_clk_i);
    {pin_rst, brown_rst, scan_rst} = 3'h0;
    repeat (6) @(negedge core_clk_i);
    rd(1'b0, d);
    `CHK(d, 8'h17)
    wr(1'b0, 8'hFF);
    rd(1'b0, d);
    `CHK(d, 8'h17)
    wr(1'b0, 8'h00);
    rd(1'b0, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_window;
    int n;
    wr(1'b1, 8'h08);
    wr(1'b1, 8'h00);
    rd(1'b1, d);
    `CHK(d, 8'h08)
    wr(1'b1, 8'h0B);
    rd(1'b1, d);
    `CHK(d, 8'h08)
    wr(1'b1, 8'h18);
    wr(1'b1, 8'h21);
    rd(1'b1, d);
    `CHK(d, 8'h21)
    wr(1'b1, 8'h39);
    n = 0;
    repeat (8) begin
      @(negedge core_clk_i);
      if (io_rdata_o[WC_CHG_EN] === 1'b1) n++;
    end
    `CHK(n, CE_HOLD_CYC)
    wr(1'b1, 8'h00);
    rd(1'b1, d);
    `CHK(d, 8'h29)
    stop_all;
  endtask

  task automatic t_irq_mode;
    wr(1'b1, 8'h40);
    kick;
    repeat (150) @(negedge core_clk_i);
    `CHK(wd_irq_o, 1'b0)
    rd(1'b1, d);
    `CHK(d, 8'hC0)
    global_irq_en_i = 1;
    @(negedge core_clk_i);
    `CHK(wd_irq_o, 1'b1)
    kick;
    wr(1'b1, 8'hC0);
    rd(1'b1, d);
    `CHK(d, 8'h40)
    wait_irq;
    ack;
    `CHK(wd_irq_o, 1'b0)
    rd(1'b1, d);
    `CHK(d, 8'h40)
    wr(1'b1, 8'h00);
  endtask

  task automatic t_combined;
    wr(1'b1, 8'h48);
    kick;
    wait_irq;
    `CHK(wd_sysreset_o, 1'b0)
    ack;
    rd(1'b1, d);
    `CHK(d, 8'h08)
    wait_rst(t1);
    kick;
    rd(1'b0, d);
    `CHK(d, 8'h08)
    wr(1'b1, 8'h18);
    wr(1'b1, 8'h00);
    rd(1'b1, d);
    `CHK(d, 8'h08)
    stop_all;
    wr(1'b1, 8'h48);
    kick;
    t0 = $time;
    wait_rst(t1);
    `CHK((t1 - t0) > BASE * OSC_P + 100, 1'b1)
    stop_all;
  endtask

  task automatic t_prescale;
    int n;
    wr(1'b1, 8'h08);
    meas(0);
    wr(1'b1, 8'h18);
    wr(1'b1, 8'h09);
    meas(1);
    stop_all;
    kick;
    n = 0;
    repeat (300) begin
      @(negedge core_clk_i);
      if (wd_sysreset_o !== 1'b0 || wd_irq_o !== 1'b0) n++;
    end
    `CHK(n, 0)
  endtask

  // A programmed fuse must win over any written mode bits.
  task automatic t_fuse;
    fuse = 0;
    repeat (8) @(negedge core_clk_i);
    wr(1'b1, 8'h40);
    rd(1'b1, d);
    `CHK(d, 8'h08)
    meas(0);
    fuse = 1;
    repeat (8) @(negedge core_clk_i);
    stop_all;
  endtask

  // A power-on reset in mid-run clears every cause but power-on and stops the watchdog.
  task automatic t_por;
    wr(1'b1, 8'h08);
    kick;
    wait_rst(t1);
    @(negedge core_clk_i);
    {pin_rst, brown_rst, scan_rst} = 3'h7;
    repeat (5) @(negedge core_clk_i);
    {pin_rst, brown_rst, scan_rst} = 3'h0;
    repeat (6) @(negedge core_clk_i);
    rd(1'b0, d);
    `CHK(d, 8'h1E)
    arst_n_i = 0;
    repeat (2) @(negedge core_clk_i);
    arst_n_i = 1;
    repeat (8) @(negedge core_clk_i);
    rd(1'b0, d);
    `CHK(d, 8'h01)
    rd(1'b1, d);
    `CHK(d, 8'h00)
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    arst_n_i = 1;
    repeat (8) @(negedge core_clk_i);
    t_reset_values;
    t_causes;
    t_window;
    t_irq_mode;
    t_combined;
    t_prescale;
    t_fuse;
    t_por;
    tally_and_finish;
  end
endmodule
